// File: hdl/lafs_pkg.sv
// Purpose: Shared constants for the load-adaptive fullstep controller
// Assumes: Avalon-MM word addressing, 32-bit data
// Notes: Offsets are register indices; byte address is four times the index
package lafs_pkg;
  localparam logic [6:0] LAFS_REG_GCONF = 7'h00;
  localparam logic [6:0] LAFS_REG_REFCONF = 7'h01;
  localparam logic [6:0] LAFS_REG_SWVEL = 7'h1d;
  localparam logic [6:0] LAFS_REG_THRVEL = 7'h60;
  localparam logic [6:0] LAFS_REG_TIMING = 7'h61;
  localparam logic [6:0] LAFS_REG_LSPTM = 7'h62;
  localparam logic [6:0] LAFS_REG_COVLO = 7'h6c;
  localparam logic [6:0] LAFS_REG_COVHI = 7'h6d;
  localparam logic [6:0] LAFS_REG_STATUS = 7'h70;
  localparam logic [6:0] LAFS_REG_IRQMASK = 7'h71;
  localparam logic [6:0] LAFS_REG_VEL = 7'h72;
  localparam logic [6:0] LAFS_REG_DRVSTAT = 7'h73;
  localparam int LAFS_MODE_LSB = 21;
  localparam int LAFS_FMT_LSB = 0;
  localparam int LAFS_COVER_BIT = 0;
  localparam logic [1:0] LAFS_MODE_EN = 2'h1;
  localparam logic [3:0] LAFS_FMT_A0 = 4'hb;
  localparam logic [3:0] LAFS_FMT_A1 = 4'ha;
  localparam logic [3:0] LAFS_FMT_B0 = 4'hd;
  localparam logic [3:0] LAFS_FMT_B1 = 4'hc;
  localparam int LAFS_SG_SHIFT = 4;
  localparam int LAFS_ST_STALL = 0;
  localparam int LAFS_ST_FORCED = 1;
  localparam int LAFS_ST_ACTIVE = 2;
  localparam logic [31:0] LAFS_RST_WORD = 32'h0000_0000;
  localparam logic [3:0] LAFS_RST_IRQ = 4'h0;
  localparam logic [15:0] LAFS_RST_CNT = 16'h0000;
  localparam logic [31:0] LAFS_ERR_WORD = 32'hdead_beef;
endpackage : lafs_pkg

// File: hdl/lafs_pulse_meter.sv
// Purpose: Measures high-time of the feedback input in clock cycles
// Assumes: Input already synchronous to ref_clk
// Notes: Count saturates so very long pulses stay long
`timescale 1ns/100ps
`default_nettype none
module lafs_pulse_meter
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pulse input
  input wire logic pulse_in,
  // Measurement
  output logic [15:0] width,
  output logic done,
  output logic high
);
  import lafs_pkg::*;
  typedef struct packed
  {
    logic prev;
    logic [15:0] cnt;
    logic [15:0] width;
    logic done;
  } lafs_pm_t;
  lafs_pm_t s_q, s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.prev = pulse_in;
    s_d.done = 1'b0;
    if (pulse_in && s_q.cnt != 16'hffff)
    begin
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    if (!pulse_in && s_q.prev)
    begin
      s_d.width = s_q.cnt;
      s_d.done = 1'b1;
      s_d.cnt = LAFS_RST_CNT;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign width = s_q.width;
  assign done = s_q.done;
  assign high = s_q.prev;
endmodule : lafs_pulse_meter
`default_nettype wire

// File: hdl/lafs_ctrl.sv
// Purpose: Load-adaptive fullstep control with Avalon-MM register access
// Assumes: ramp_velocity is signed and synchronous; feedback already synchronous
// Notes: Step gating and handshake outputs are registered
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Mode code 01 at bits 22:21 enables
// - Write-only 24-bit threshold velocity at 0x60
// - Active only while absolute velocity exceeds threshold
// - Internal: step allowed when on-time below limit
// - Overload pauses internal step generation
// - First checked pulse shorter than limit*16 stalls
// - Blank time ignores pulses after fullstep release
// - Internal stall result replaces driver stall bit
// - Low-speed timer expiry forces one step
// - Formats 1011/1010 select internal generation
// - Formats 1101/1100 select driver handshake
// - Handshake output high when velocity reaches threshold
// - Handshake mode keeps emitting microsteps
// - Auto cover sends low/high chopper datagram
module lafs_ctrl
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Ramp side
  input wire logic signed [31:0] ramp_velocity,
  input wire logic step_request,
  output logic step_enable,
  output logic step_forced,
  // Driver side
  input wire logic feedback_input,
  input wire logic driver_stall_in,
  output logic handshake_output,
  output logic stall_flag,
  output logic [31:0] chopper_datagram,
  output logic datagram_valid,
  // Interrupt
  output logic irq
);
  import lafs_pkg::*;

  typedef enum logic [2:0]
  {
    LAFS_BUS_IDLE = 3'b001,
    LAFS_BUS_ACK = 3'b010,
    LAFS_BUS_WAIT = 3'b100
  } lafs_bus_t;

  typedef struct packed
  {
    lafs_bus_t bus;
    logic [31:0] gconf;
    logic [31:0] refconf;
    logic [31:0] swvel;
    logic [23:0] thrvel;
    logic [31:0] timing;
    logic [31:0] lsptm;
    logic [31:0] covlo;
    logic [31:0] covhi;
    logic [3:0] status;
    logic [3:0] mask;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic pause;
    logic [15:0] blank;
    logic armed;
    logic stall;
    logic [31:0] lsp_cnt;
    logic step_en;
    logic forced;
    logic hs;
    logic active;
    logic cover_sel;
    logic [31:0] dgram;
    logic dvalid;
    logic irq;
    logic stall_out;
  } lafs_state_t;

  lafs_state_t s_q, s_d;
  logic [15:0] pm_width;
  logic pm_done;
  logic pm_high;

  lafs_pulse_meter u_meter
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pulse_in(feedback_input),
    .width(pm_width),
    .done(pm_done),
    .high(pm_high)
  );

  function automatic logic [31:0] lafs_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : lafs_merge

  function automatic logic lafs_known(input logic [6:0] a);
    case (a)
      LAFS_REG_GCONF, LAFS_REG_REFCONF, LAFS_REG_SWVEL, LAFS_REG_THRVEL, LAFS_REG_TIMING,
      LAFS_REG_LSPTM, LAFS_REG_COVLO, LAFS_REG_COVHI, LAFS_REG_STATUS, LAFS_REG_IRQMASK,
      LAFS_REG_VEL, LAFS_REG_DRVSTAT: lafs_known = 1'b1;
      default: lafs_known = 1'b0;
    endcase
  endfunction : lafs_known

  logic mode_en;
  logic [3:0] fmt;
  logic fam_int;
  logic fam_hs;
  logic [31:0] abs_vel;
  logic above;
  logic at_or_above;
  logic [7:0] on_limit;
  logic [11:0] sg_limit;
  logic [15:0] blank_time;
  logic ev_stall;
  logic ev_forced;
  logic ev_active;

  always_comb
  begin
    s_d = s_q;
    mode_en = s_q.gconf[LAFS_MODE_LSB +: 2] == LAFS_MODE_EN;
    fmt = s_q.gconf[LAFS_FMT_LSB +: 4];
    fam_int = (fmt == LAFS_FMT_A0) || (fmt == LAFS_FMT_A1);
    fam_hs = (fmt == LAFS_FMT_B0) || (fmt == LAFS_FMT_B1);
    abs_vel = ramp_velocity[31] ? 32'(-ramp_velocity) : ramp_velocity;
    above = abs_vel > {8'h00, s_q.thrvel};
    at_or_above = ramp_velocity >= $signed({8'h00, s_q.thrvel});
    on_limit = s_q.timing[7:0];
    sg_limit = {s_q.timing[15:8], 4'h0};
    blank_time = s_q.timing[31:16];
    ev_stall = 1'b0;
    ev_forced = 1'b0;
    s_d.active = mode_en && above;
    ev_active = s_d.active && !s_q.active;
    s_d.forced = 1'b0;
    s_d.dvalid = 1'b0;

    // Bus: two wait cycles, then answer; keeps decode off the read path
    case (s_q.bus)
      LAFS_BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          s_d.bus = LAFS_BUS_ACK;
        end
      end
      LAFS_BUS_ACK:
      begin
        s_d.bus = LAFS_BUS_WAIT;
        s_d.resp = lafs_known(avs_address) ? 2'h0 : 2'h2;
        s_d.rdata = 32'h0000_0000;
        if (avs_read)
        begin
          case (avs_address)
            LAFS_REG_GCONF: s_d.rdata = s_q.gconf;
            LAFS_REG_REFCONF: s_d.rdata = s_q.refconf;
            LAFS_REG_STATUS: s_d.rdata = {28'h0, s_q.status};
            LAFS_REG_IRQMASK: s_d.rdata = {28'h0, s_q.mask};
            LAFS_REG_VEL: s_d.rdata = abs_vel;
            LAFS_REG_DRVSTAT: s_d.rdata = {29'h0, s_q.active, s_q.pause, stall_flag};
            default: s_d.rdata = lafs_known(avs_address) ? 32'h0000_0000 : LAFS_ERR_WORD;
          endcase
        end
        if (avs_write)
        begin
          case (avs_address)
            LAFS_REG_GCONF: s_d.gconf = lafs_merge(s_q.gconf, avs_writedata, avs_byteenable);
            LAFS_REG_REFCONF: s_d.refconf = lafs_merge(s_q.refconf, avs_writedata, avs_byteenable);
            LAFS_REG_SWVEL: s_d.swvel = lafs_merge(s_q.swvel, avs_writedata, avs_byteenable);
            LAFS_REG_THRVEL: s_d.thrvel = 24'(lafs_merge({8'h00, s_q.thrvel}, avs_writedata, avs_byteenable));
            LAFS_REG_TIMING: s_d.timing = lafs_merge(s_q.timing, avs_writedata, avs_byteenable);
            LAFS_REG_LSPTM: s_d.lsptm = lafs_merge(s_q.lsptm, avs_writedata, avs_byteenable);
            LAFS_REG_COVLO: s_d.covlo = lafs_merge(s_q.covlo, avs_writedata, avs_byteenable);
            LAFS_REG_COVHI: s_d.covhi = lafs_merge(s_q.covhi, avs_writedata, avs_byteenable);
            LAFS_REG_STATUS:
            begin
              if (avs_byteenable[0])
              begin
                s_d.status = s_q.status & ~avs_writedata[3:0];
              end
            end
            LAFS_REG_IRQMASK:
            begin
              if (avs_byteenable[0])
              begin
                s_d.mask = avs_writedata[3:0];
              end
            end
            default: s_d.bus = LAFS_BUS_WAIT;
          endcase
        end
      end
      LAFS_BUS_WAIT: s_d.bus = LAFS_BUS_IDLE;
      default: s_d.bus = LAFS_BUS_IDLE;
    endcase

    // Internal generation: pause while on-time runs long
    if (!mode_en)
    begin
      s_d.pause = 1'b0;
      s_d.armed = 1'b0;
      s_d.blank = LAFS_RST_CNT;
      s_d.lsp_cnt = LAFS_RST_WORD;
    end
    else if (fam_int && s_q.active)
    begin
      // Pulse high while the last measured width is at or past limit means overload
      if (pm_high && !s_q.pause && (pm_width >= {8'h00, on_limit} || 1'b0))
      begin
        s_d.pause = 1'b1;
      end
      if (pm_done)
      begin
        s_d.pause = pm_width >= {8'h00, on_limit};
      end
      if (s_q.blank != LAFS_RST_CNT)
      begin
        s_d.blank = s_q.blank - 16'h0001;
      end
      else if (pm_done && s_q.armed)
      begin
        s_d.armed = 1'b0;
        if (pm_width < {4'h0, sg_limit})
        begin
          s_d.stall = 1'b1;
          ev_stall = 1'b1;
        end
      end
      // Low-speed timer: pause must lift within lsptm cycles
      if (s_q.pause && s_d.pause)
      begin
        s_d.lsp_cnt = s_q.lsp_cnt + 32'h0000_0001;
        if (s_d.lsp_cnt >= s_q.lsptm && s_q.lsptm != LAFS_RST_WORD)
        begin
          s_d.forced = 1'b1;
          ev_forced = 1'b1;
          s_d.lsp_cnt = LAFS_RST_WORD;
        end
      end
      else
      begin
        s_d.lsp_cnt = LAFS_RST_WORD;
      end
      // Each released step restarts blank and check
      if ((step_request && !s_q.pause) || s_d.forced)
      begin
        s_d.blank = blank_time;
        s_d.armed = 1'b1;
        s_d.stall = 1'b0;
      end
    end
    else
    begin
      s_d.pause = 1'b0;
      s_d.lsp_cnt = LAFS_RST_WORD;
    end

    // Internal mode gates steps; handshake mode never gates
    s_d.step_en = !(fam_int && mode_en && s_q.active && s_d.pause) || s_d.forced;
    s_d.hs = fam_hs && mode_en && at_or_above;
    // Stall bit source swap
    s_d.stall_out = fam_int ? s_d.stall : driver_stall_in;
    s_d.irq = 1'b0;

    // Chopper datagram swap on threshold crossing
    if (s_q.refconf[LAFS_COVER_BIT])
    begin
      s_d.cover_sel = s_d.active;
      s_d.dgram = s_d.active ? s_q.covhi : s_q.covlo;
      // Any change of the word is announced, also a rewrite while enabled
      s_d.dvalid = (s_d.cover_sel != s_q.cover_sel) || (s_d.dgram != s_q.dgram);
    end

    // Sticky events: set wins over write-one-clear
    if (ev_stall)
    begin
      s_d.status[LAFS_ST_STALL] = 1'b1;
    end
    if (ev_forced)
    begin
      s_d.status[LAFS_ST_FORCED] = 1'b1;
    end
    if (ev_active)
    begin
      s_d.status[LAFS_ST_ACTIVE] = 1'b1;
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.bus <= LAFS_BUS_IDLE;
      s_q.status <= LAFS_RST_IRQ;
      s_q.mask <= LAFS_RST_IRQ;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (s_q.bus != LAFS_BUS_WAIT);
  assign avs_readdata = s_q.rdata;
  assign avs_response = s_q.resp;
  assign step_enable = s_q.step_en;
  assign step_forced = s_q.forced;
  assign handshake_output = s_q.hs;
  assign stall_flag = s_q.stall_out;
  assign chopper_datagram = s_q.dgram;
  assign datagram_valid = s_q.dvalid;
  assign irq = s_q.irq;
endmodule : lafs_ctrl
`default_nettype wire

// File: sim/lafs_drv_model.sv
// Purpose: Driver model giving on-time pulses on the feedback line
// Assumes: Width in clock cycles set by bench; zero keeps the line low
// Notes: Fixed 20-cycle low gap, like a chopper under steady load
`timescale 1ns/100ps
`default_nettype none
module lafs_drv_model
(
  // Clock
  input wire logic ref_clk,
  // Pulse control
  input wire logic [7:0] width,
  // Feedback line
  output logic pulse_out = 1'b0
);
  logic [8:0] cnt_q = 9'h000;
  always @(posedge ref_clk)
  begin
    cnt_q <= (cnt_q >= {1'b0, width} + 9'h013) ? 9'h000 : cnt_q + 9'h001;
    pulse_out <= (width != 8'h00) && (cnt_q < {1'b0, width});
  end
endmodule : lafs_drv_model
`default_nettype wire

// File: sim/lafs_ctrl_chk.sv
// Purpose: Port assertions for lafs_ctrl
// Assumes: Bus answer fixed two cycles after a taken request
// Notes: Register contents are hidden, so only port relations
`timescale 1ns/100ps
`default_nettype none
module lafs_ctrl_chk
  import lafs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // Ramp and driver
  input wire logic signed [31:0] ramp_velocity,
  input wire logic step_enable,
  input wire logic step_forced,
  input wire logic handshake_output,
  input wire logic stall_flag,
  input wire logic [31:0] chopper_datagram,
  input wire logic datagram_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_read_latency: assert property ($rose(avs_read) |-> avs_waitrequest [*2] ##1 !avs_waitrequest)
    else $error("read answer not on third edge");
  a_write_latency: assert property ($rose(avs_write) |-> avs_waitrequest [*2] ##1 !avs_waitrequest)
    else $error("write answer not on third edge");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_cause: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("answer without request");
  a_err_data: assert property (!avs_waitrequest && avs_read && avs_response == 2'h2
    |-> avs_readdata == LAFS_ERR_WORD)
    else $error("unmapped read data wrong");
  a_data_stands: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
    else $error("readdata moved outside answer");
  a_forced_pulse: assert property (step_forced |=> !step_forced)
    else $error("forced step longer than a cycle");
  a_forced_paused: assert property (step_forced |-> !$past(step_enable))
    else $error("forced step while not paused");
  a_valid_change: assert property ($changed(chopper_datagram) |-> datagram_valid)
    else $error("datagram changed without valid");
  a_hs_sign: assert property (handshake_output |-> !$past(ramp_velocity[31]))
    else $error("handshake high on negative velocity");
  c_stall: cover property ($rose(stall_flag));
  c_forced: cover property (step_forced);
  c_hs: cover property ($rose(handshake_output));
endmodule : lafs_ctrl_chk
bind lafs_ctrl lafs_ctrl_chk u_chk (.ref_clk, .rst_n, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .avs_response, .ramp_velocity, .step_enable, .step_forced, .handshake_output,
  .stall_flag, .chopper_datagram, .datagram_valid);
`default_nettype wire

// File: sim/lafs_ctrl_bench.sv
// Purpose: Self-checking bench for lafs_ctrl
// Assumes: Seed 70; one outstanding bus request
// Notes: Reads queue expected words; monitor pops on answer
`timescale 1ns/100ps
`default_nettype none
module lafs_ctrl_bench;
  import lafs_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] adr = 7'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic signed [31:0] vel = 32'sh0;
  logic sreq = 1'b0;
  logic dstall = 1'b0;
  logic seenf = 1'b0;
  logic [7:0] pw = 8'h00;
  logic [31:0] rdata, dgram, lo, hi;
  logic [1:0] resp;
  logic wt, sen, sfrc, fb, hs, stl, dv, irq;
  logic [33:0] expq[$];
  logic [3:0] fmt [4] = '{LAFS_FMT_B0, LAFS_FMT_B1, LAFS_FMT_A0, LAFS_FMT_A1};
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int dvn = 0;
  int r;
  always #2 ref_clk = ~ref_clk;
  lafs_ctrl uut (.ref_clk, .rst_n, .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wt), .avs_response(resp),
    .ramp_velocity(vel), .step_request(sreq), .step_enable(sen), .step_forced(sfrc), .feedback_input(fb),
    .driver_stall_in(dstall), .handshake_output(hs), .stall_flag(stl), .chopper_datagram(dgram),
    .datagram_valid(dv), .irq);
  lafs_drv_model drv (.ref_clk, .width(pw), .pulse_out(fb));
  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chb(input logic got, input logic exp);
    chk({33'h0, got}, {33'h0, exp});
  endtask : chb
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    rd <= !w;
    wr <= w;
    do @(posedge ref_clk); while (wt !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic rdx(input logic [6:0] a, input logic [33:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rdx
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (sfrc === 1'b1)
      seenf <= 1'b1;
    if (dv === 1'b1)
      dvn <= dvn + 1;
    if (rd && wt === 1'b0 && expq.size() > 0)
      chk({resp, rdata}, expq.pop_front());
    if (cyc > 20000)
    begin
      err_count++;
      conclude();
    end
  end
  initial
  begin
    r = $urandom(70);
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    tick(2);
    r = int'($urandom_range(5000, 1));
    vel <= -r;
    rdx(7'h05, {2'h2, LAFS_ERR_WORD});
    bus(1'b1, LAFS_REG_THRVEL, 32'h0000_03e8);
    rdx(LAFS_REG_THRVEL, 34'h0);
    rdx(LAFS_REG_VEL, {2'h0, 32'(r)});
    $display("Test registers done");
    // In handshake formats the threshold itself must raise the handshake, one below must not
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, LAFS_REG_GCONF, {9'h0, LAFS_MODE_EN, 17'h0, fmt[i]});
      vel <= 32'sd1000;
      tick(3);
      chb(hs, i < 2);
      chb(sen, 1'b1);
      vel <= 32'sd999;
      tick(3);
      chb(hs, 1'b0);
    end
    bus(1'b1, LAFS_REG_GCONF, {9'h0, 2'h2, 17'h0, LAFS_FMT_B0});
    vel <= 32'sd1000;
    tick(3);
    chb(hs, 1'b0);
    $display("Test handshake done");
    bus(1'b1, LAFS_REG_GCONF, {9'h0, LAFS_MODE_EN, 17'h0, LAFS_FMT_A0});
    bus(1'b1, LAFS_REG_STATUS, 32'h7);
    bus(1'b1, LAFS_REG_IRQMASK, 32'h0);
    bus(1'b1, LAFS_REG_TIMING, 32'h000a_0228);
    bus(1'b1, LAFS_REG_LSPTM, 32'd60);
    pw <= 8'd60;
    vel <= 32'sd2000;
    tick(400);
    // A forced step opens the gate for one cycle; look past it
    if (sfrc === 1'b1)
      tick(1);
    chb(sen, 1'b0);
    chb(seenf, 1'b1);
    chb(irq, 1'b0);
    bus(1'b1, LAFS_REG_IRQMASK, 32'h7);
    tick(2);
    chb(irq, 1'b1);
    rdx(LAFS_REG_STATUS, {2'h0, 32'h6});
    pw <= 8'd20;
    tick(300);
    chb(sen, 1'b1);
    sreq <= 1'b1;
    tick(1);
    sreq <= 1'b0;
    tick(300);
    chb(stl, 1'b1);
    bus(1'b1, LAFS_REG_STATUS, 32'h7);
    tick(2);
    chb(irq, 1'b0);
    rdx(LAFS_REG_STATUS, 34'h0);
    $display("Test internal gating done");
    lo = $urandom;
    hi = $urandom;
    bus(1'b1, LAFS_REG_COVLO, lo);
    bus(1'b1, LAFS_REG_COVHI, hi);
    bus(1'b1, LAFS_REG_SWVEL, 32'd990);
    bus(1'b1, LAFS_REG_REFCONF, 32'h1);
    tick(4);
    chk({2'h0, dgram}, {2'h0, hi});
    chk(34'(dvn), 34'h1);
    vel <= 32'sh0;
    tick(4);
    chk({2'h0, dgram}, {2'h0, lo});
    chk(34'(dvn), 34'h2);
    $display("Test cover done");
    // Mode off must drop the pause even with overlong pulses
    bus(1'b1, LAFS_REG_GCONF, {9'h0, 2'h0, 17'h0, LAFS_FMT_A0});
    pw <= 8'd60;
    vel <= 32'sd2000;
    tick(300);
    chb(sen, 1'b1);
    bus(1'b1, LAFS_REG_GCONF, {9'h0, LAFS_MODE_EN, 17'h0, LAFS_FMT_B0});
    dstall <= 1'($urandom);
    tick(3);
    chb(stl, dstall);
    $display("Test mode exit done");
    conclude();
  end
endmodule : lafs_ctrl_bench
`default_nettype wire
